// ===== pkg/guard_pkg.sv
// Constants, field layouts and carried types of the watchdog control unit.
// Assumes an AXI4-Lite master with 32-bit data and a 16-bit byte address.
package guard_pkg;
  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [13:0] cfg_idx = 14'h0fd4; // guard_config_reg
  localparam logic [13:0] code_idx = 14'h0fd5; // guard_code_reg
  localparam logic [13:0] count_idx = 14'h0fd6; // guard_count_monitor
  localparam logic [13:0] status_idx = 14'h0fd7; // guard_status_reg
  localparam logic [13:0] mask_idx = 14'h0fd8; // Interrupt mask
  localparam logic [13:0] option_idx = 14'h0fd9; // Divider option
  // ----------------------------------------------------------------------
  // Field positions, reset values and codes
  // ----------------------------------------------------------------------
  localparam int en_bit = 5;
  localparam logic [7:0] cfg_reset = 8'ha6;
  localparam logic [1:0] cfg_top_bits = 2'h2;
  localparam logic [7:0] clear_code = 8'h4e;
  localparam logic [7:0] disable_code = 8'hb1;
  localparam logic [7:0] count_max = 8'hff;
  localparam logic [7:0] quarter = 8'h40;
  localparam logic [7:0] half = 8'h80;
  localparam logic [7:0] three_quarters = 8'hc0;
  // Prescaler exponents: overflow exponent minus the 8 counter bits
  localparam logic [4:0] gear_pre_base = 5'h0a;
  localparam logic [4:0] low_pre_base = 5'h03;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_decerr = 2'h3;
  // ----------------------------------------------------------------------
  // Carried types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [1:0] window;
    logic [1:0] period;
    logic action;
  } cfg_t;
  typedef struct packed {
    logic ovf; // Overflow with interrupt action
    logic win; // Clear code outside the clear time
  } events_t;
endpackage : guard_pkg

// ===== rtl/watchdog_control_unit.sv
// Watchdog control unit: configuration, code, monitor and status registers
// on AXI4-Lite, prescaler, 8-bit up counter, clear window and requests.
// Assumes source ticks and mode inputs are synchronous one-clock levels.
//
// Local design decision: the AXI4-Lite register port.
module watchdog_control_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Clock sources, one-cycle pulses per source period
  input wire logic gear_tick,
  input wire logic low_tick,
  // System state
  input wire logic slow_mode,
  input wire logic warmup_done,
  // Requests
  output logic guard_int_req,
  output logic guard_reset_req,
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    guard_pkg::cfg_t cfg; // guard_config_reg writable fields
    logic div_opt; // low_clock_divider_option
    logic started; // Warm-up has been seen
    logic active; // Counter is running
    logic [7:0] count; // 8-bit up counter
    logic [15:0] pre; // Prescaler
    guard_pkg::events_t sticky; // Sticky event bits
    guard_pkg::events_t mask; // Interrupt mask
    logic aw_have; // Write address held
    logic [13:0] aw_idx;
    logic w_have; // Write data held
    logic [7:0] w_byte;
    logic w_lane; // Byte lane 0 strobed
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic int_req;
    logic rst_req;
    logic irq;
  } state_t;

  state_t st; // Registered state
  state_t next_st; // Next state
  logic low_src; // Low-frequency clock is the source
  logic src_tick; // Selected source tick
  logic [4:0] pre_exp; // Prescaler width
  logic [15:0] pre_mask; // Prescaler terminal mask
  logic count_tick; // Counter advance
  logic do_write; // Write commits this cycle
  logic early; // Clear code inside the forbidden part
  logic [7:0] rd_byte; // Read mux
  logic rd_hit; // Read address mapped
  logic overflow; // Counter wraps

  // ----------------------------------------------------------------------
  // Source clock and prescaler selection
  // ----------------------------------------------------------------------
  // Low clock in slow mode or when the divider option is set
  always_comb begin
    low_src = slow_mode | st.div_opt;
    src_tick = low_src ? low_tick : gear_tick;
    pre_exp = (low_src ? guard_pkg::low_pre_base : guard_pkg::gear_pre_base)
      + {2'h0, st.cfg.period, 1'b0};
    pre_mask = 16'hffff >> (5'h10 - pre_exp);
    count_tick = st.active & src_tick & ((st.pre & pre_mask) == pre_mask);
    overflow = count_tick & (st.count == guard_pkg::count_max);
  end

  // Clear window: the lower part of the period is forbidden
  always_comb begin
    unique case (st.cfg.window)
      2'h0: early = 1'b0;
      2'h1: early = st.count < guard_pkg::quarter;
      2'h2: early = st.count < guard_pkg::half;
      2'h3: early = st.count < guard_pkg::three_quarters;
    endcase
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // Code register is write-only and reads zero
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr[15:2])
      guard_pkg::cfg_idx: rd_byte = {guard_pkg::cfg_top_bits, st.cfg};
      guard_pkg::code_idx: rd_byte = 8'h00;
      guard_pkg::count_idx: rd_byte = st.count;
      guard_pkg::status_idx: rd_byte = {5'h00, st.sticky, st.active};
      guard_pkg::mask_idx: rd_byte = {6'h00, st.mask};
      guard_pkg::option_idx: rd_byte = {7'h00, st.div_opt};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    do_write = st.aw_have & st.w_have & ~st.bvalid;
    next_st.int_req = 1'b0;
    next_st.rst_req = 1'b0;
    // Bus channel captures; address and data may arrive in either order
    if (awvalid & st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_idx = awaddr[15:2];
    end
    if (wvalid & st.wready) begin
      next_st.w_have = 1'b1;
      next_st.w_byte = wdata[7:0];
      next_st.w_lane = wstrb[0];
    end
    if (st.bvalid & bready) begin
      next_st.bvalid = 1'b0;
    end
    // Counting; prescaler runs only while active
    if (st.active & src_tick) begin
      next_st.pre = st.pre + 16'h0001;
    end
    if (count_tick) begin
      next_st.count = st.count + 8'h01; // Wraps, keeps counting
    end
    // Overflow action
    if (overflow) begin
      if (st.cfg.action) begin
        next_st.rst_req = 1'b1;
      end else begin
        next_st.int_req = 1'b1;
      end
    end
    // Automatic start once warm-up is over
    if (warmup_done & ~st.started) begin
      next_st.started = 1'b1;
      next_st.active = st.cfg.en;
    end
    // Register writes
    if (do_write) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = guard_pkg::resp_okay;
      if (st.w_lane) begin
        unique case (st.aw_idx)
          guard_pkg::cfg_idx: begin
            next_st.cfg.en = st.w_byte[guard_pkg::en_bit];
            // Fields move only while disabled or in the enabling write
            if (~st.cfg.en) begin
              next_st.cfg = st.w_byte[5:0];
            end
            if (~st.cfg.en & st.w_byte[guard_pkg::en_bit] & st.started) begin
              next_st.active = 1'b1;
            end
          end
          guard_pkg::code_idx: begin
            if (st.w_byte == guard_pkg::clear_code && st.active) begin
              if (early) begin
                next_st.sticky.win = 1'b1;
                next_st.int_req = 1'b1;
              end else begin
                next_st.count = 8'h00;
                next_st.pre = 16'h0000;
              end
            end
            // Disable takes priority over a coincident overflow
            if (st.w_byte == guard_pkg::disable_code && ~st.cfg.en) begin
              next_st.active = 1'b0;
              next_st.count = 8'h00;
              next_st.pre = 16'h0000;
              next_st.int_req = 1'b0;
              next_st.rst_req = 1'b0;
            end
          end
          guard_pkg::status_idx: begin
            next_st.sticky = st.sticky & ~st.w_byte[2:1];
          end
          guard_pkg::mask_idx: next_st.mask = st.w_byte[1:0];
          guard_pkg::option_idx: next_st.div_opt = st.w_byte[0];
          guard_pkg::count_idx: next_st.bresp = guard_pkg::resp_okay;
          default: next_st.bresp = guard_pkg::resp_decerr;
        endcase
      end
    end
    // Events set after clears so a coincident event is kept
    if (overflow & ~st.cfg.action & next_st.int_req) begin
      next_st.sticky.ovf = 1'b1;
    end
    if (next_st.int_req & ~overflow) begin
      next_st.sticky.win = 1'b1;
    end
    // Read channel
    if (st.rvalid & rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid & st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = {24'h000000, rd_byte};
      next_st.rresp = rd_hit ? guard_pkg::resp_okay : guard_pkg::resp_decerr;
    end
    // One write and one read in flight; ready drops while holding
    next_st.awready = ~next_st.aw_have & ~next_st.bvalid;
    next_st.wready = ~next_st.w_have & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;
    next_st.irq = |(next_st.sticky & next_st.mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronous reset; everything takes constants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.cfg <= guard_pkg::cfg_reset[5:0];
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------------
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign guard_int_req = st.int_req;
  assign guard_reset_req = st.rst_req;
  assign irq = st.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  auto_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    warmup_done && !st.started && st.cfg.en |=> st.active)
    else $error("watchdog did not start after warm-up");

  stopped_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.active && !(warmup_done && !st.started) && !do_write |=>
    $stable(st.count))
    else $error("counter moved while stopped");

  early_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && st.w_lane && st.aw_idx == guard_pkg::code_idx &&
    st.w_byte == guard_pkg::clear_code && st.active && early |=>
    guard_int_req && st.sticky.win)
    else $error("early clear code did not raise interrupt");

  late_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && st.w_lane && st.aw_idx == guard_pkg::code_idx &&
    st.w_byte == guard_pkg::clear_code && st.active && !early |=>
    st.count == 8'h00)
    else $error("clear code did not clear counter");

  ovf_action_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow && !(do_write && st.aw_idx == guard_pkg::code_idx) |=>
    (guard_reset_req == $past(st.cfg.action)) &&
    (guard_int_req == !$past(st.cfg.action)))
    else $error("overflow produced the wrong request");

  frozen_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.en |=> $stable(st.cfg[4:0]))
    else $error("fields changed while enabled");

  top_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && st.arready && araddr[15:2] == guard_pkg::cfg_idx |=>
    rvalid && rdata[7:6] == 2'h2)
    else $error("config top bits read wrong");

  disable_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    do_write && st.w_lane && st.aw_idx == guard_pkg::code_idx &&
    st.w_byte == guard_pkg::disable_code && !st.cfg.en |=>
    !st.active && st.count == 8'h00 && !guard_reset_req ##1
    st.count == 8'h00)
    else $error("disable sequence did not stop counter");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == |($past(next_st.sticky) & $past(next_st.mask)))
    else $error("interrupt level mismatch");

endmodule // watchdog_control_unit

// ===== tb/cpu_model.sv
// CPU-side register bus master for the watchdog control unit.
// Assumes the bench calls one task at a time, just after a rising edge.
module cpu_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [15:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [15:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // One byte write; random upper data bits must be ignored
  task automatic wr(input logic [13:0] idx, input logic [7:0] v,
                    output bit ok);
    logic [31:0] rnd;
    bit aw_t;
    bit w_t;
    rnd = $urandom();
    aw_t = 0;
    w_t = 0;
    ok = 0;
    awaddr <= {idx, 2'h0};
    wdata <= {rnd[31:8], v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (200) begin
      @(posedge aclk);
      // Released lines show the inverse, never a stale value
      if (!aw_t && awready) begin
        aw_t = 1;
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (!w_t && wready) begin
        w_t = 1;
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid) begin
        bready <= 1'b0;
        ok = 1;
        break;
      end
    end
    // Spare edge so a following task never re-drives in this step
    @(posedge aclk);
  endtask
  // One read; the bench's monitor judges the data
  task automatic rd(input logic [13:0] idx, output bit ok);
    ok = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (200) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid) begin
        rready <= 1'b0;
        ok = 1;
        break;
      end
    end
    @(posedge aclk);
  endtask
  // Stop sequence: enable bit cleared first, then the disable code
  task automatic halt(input logic [7:0] cfg, output bit ok);
    wr(guard_pkg::cfg_idx, cfg, ok);
    if (ok) begin
      wr(guard_pkg::code_idx, guard_pkg::disable_code, ok);
    end
  endtask
endmodule // cpu_model

// ===== tb/testbench.sv
// Self-checking bench for the watchdog control unit.
// Assumes ticks every cycle: 8 cycles a count on the low source at period 00.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, gear_tick, low_tick, slow_mode;
  logic warmup_done, guard_int_req, guard_reset_req, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  exp_t exp_q[$]; // Expected read results, oldest first
  logic [1:0] bexp_q[$]; // Expected write responses, oldest first
  int fail_count = 0;
  int cmp_count = 0;
  int int_n = 0; // Interrupt request pulses seen
  int rst_n = 0; // Reset request pulses seen
  int n;
  bit ok;
  watchdog_control_unit uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .gear_tick(gear_tick), .low_tick(low_tick),
    .slow_mode(slow_mode), .warmup_done(warmup_done),
    .guard_int_req(guard_int_req), .guard_reset_req(guard_reset_req),
    .irq(irq));
  cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
  // ----------------------------------------------------------------
  // Clock, 40 ns period
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Verdict, the single place the run ends
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // Bus wrappers; a hung handshake ends the run
  task automatic wrx(logic [13:0] i, logic [7:0] v);
    bexp_q.push_back((i < guard_pkg::cfg_idx || i > guard_pkg::option_idx) ?
      guard_pkg::resp_decerr : guard_pkg::resp_okay);
    cpu.wr(i, v, ok);
    if (!ok) begin fail_count++; print_verdict(); end
  endtask
  task automatic rdx(logic [13:0] i, logic [31:0] d, logic [31:0] m,
                     logic [1:0] r);
    exp_q.push_back('{d, m, r});
    cpu.rd(i, ok);
    if (!ok) begin fail_count++; print_verdict(); end
  endtask
  task automatic haltx();
    bexp_q.push_back(guard_pkg::resp_okay);
    bexp_q.push_back(guard_pkg::resp_okay);
    cpu.halt(8'h00, ok);
    if (!ok) begin fail_count++; print_verdict(); end
  endtask
  // Read monitor: oldest note against each read beat
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
      else begin
        chk("rdata", exp_q[0].d, rdata & exp_q[0].m);
        chk("rresp", {30'h0, exp_q[0].r}, {30'h0, rresp});
        void'(exp_q.pop_front());
      end
    end
  end
  // Write response monitor: oldest note against each response beat
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (bexp_q.size() == 0) chk("unexpected bresp", 32'h0, 32'h1);
      else begin
        chk("bresp", {30'h0, bexp_q[0]}, {30'h0, bresp});
        void'(bexp_q.pop_front());
      end
    end
  end
  // Request pulse counters
  always @(posedge aclk) begin
    if (guard_int_req === 1'b1) int_n <= int_n + 1;
    if (guard_reset_req === 1'b1) rst_n <= rst_n + 1;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, gear_tick, low_tick, slow_mode, warmup_done} = '0;
    void'($urandom(32'heb4fa157));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    gear_tick <= 1'b1;
    low_tick <= 1'b1;
    repeat (2) @(posedge aclk);
    rdx(guard_pkg::cfg_idx, 32'ha6, 32'hffffffff, 2'h0);
    rdx(guard_pkg::status_idx, 32'h0, 32'h1, 2'h0);
    warmup_done <= 1'b1;
    repeat (2) @(posedge aclk);
    rdx(guard_pkg::status_idx, 32'h1, 32'h1, 2'h0);
    // Field writes while running are dropped
    wrx(guard_pkg::cfg_idx, 8'h39);
    rdx(guard_pkg::cfg_idx, 32'ha6, 32'hff, 2'h0);
    rdx(guard_pkg::code_idx, 32'h0, 32'hff, 2'h0);
    rdx(14'h0fda, 32'h0, 32'hffffffff, 2'h3);
    wrx(14'h0fda, 8'hff);
    haltx();
    rdx(guard_pkg::cfg_idx, 32'h86, 32'hff, 2'h0);
    rdx(guard_pkg::count_idx, 32'h0, 32'hff, 2'h0);
    rdx(guard_pkg::status_idx, 32'h0, 32'h1, 2'h0);
    // Gear source, shortest period: 1024 cycles a count
    low_tick <= 1'b0; // Only the gear tick may move the counter here
    wrx(guard_pkg::cfg_idx, 8'h20);
    repeat (3 * 1024 + 512) @(posedge aclk);
    rdx(guard_pkg::count_idx, 32'h3, 32'hff, 2'h0);
    low_tick <= 1'b1;
    wrx(guard_pkg::option_idx, 8'h01);
    // Every clear window: clear at once, early except in window 00, then late clear
    for (int w = 0; w < 4; w++) begin
      haltx();
      wrx(guard_pkg::cfg_idx, 8'h20 | 8'(w << 3));
      n = int_n;
      wrx(guard_pkg::code_idx, guard_pkg::clear_code);
      repeat (3) @(posedge aclk);
      chk("early clear", 32'(n + (w != 0)), 32'(int_n));
      repeat ((w * 64 + 4) * 8) @(posedge aclk);
      n = int_n;
      wrx(guard_pkg::code_idx, guard_pkg::clear_code);
      repeat (3) @(posedge aclk);
      chk("late clear", 32'(n), 32'(int_n));
      rdx(guard_pkg::count_idx, 32'h0, 32'hf8, 2'h0);
    end
    // Early-clear sticky bit drives the interrupt once unmasked
    wrx(guard_pkg::mask_idx, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    wrx(guard_pkg::status_idx, 8'h02);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    // Overflow with interrupt action: 256 counts of 8 cycles
    haltx();
    wrx(guard_pkg::cfg_idx, 8'h20);
    n = int_n;
    repeat (2030) @(posedge aclk);
    chk("ovf int early", 32'(n), 32'(int_n));
    repeat (40) @(posedge aclk);
    chk("ovf int", 32'(n + 1), 32'(int_n));
    rdx(guard_pkg::status_idx, 32'h5, 32'h7, 2'h0);
    // Slow mode, period 01, reset action: 256 counts of 32 cycles
    haltx();
    wrx(guard_pkg::option_idx, 8'h00);
    slow_mode <= 1'b1;
    gear_tick <= 1'b0; // Only the low tick may move the counter here
    wrx(guard_pkg::cfg_idx, 8'h23);
    n = rst_n;
    repeat (8150) @(posedge aclk);
    chk("ovf rst early", 32'(n), 32'(rst_n));
    repeat (80) @(posedge aclk);
    chk("ovf rst", 32'(n + 1), 32'(rst_n));
    chk("notes left", 32'h0, 32'(exp_q.size() + bexp_q.size()));
    print_verdict();
  end
endmodule // testbench
